// File: verilog/ranging_host.sv
// host end: ranging sequencer with register port and interrupt
// Overview of operation
// [R01] host enters crystal standby before readout
// [R02] host sets memory clock bit by rmw
// [R03] host writes result type bits 5:4
// [R04] result bytes msb, mid, lsb at 961-963
// [R05] host returns to rc standby after readout
// [R06] config in init, start in request states
// [R07] initiator reads result in store state
// [R08] timeout or discard retries until error limit
// [R09] device handles response leg itself
// [R10] overhear mode measures request-response difference
// [R11] overhear entry: responder role first
// [R12] then enable overhear and start reception
// [R13] bit 15 means overhear done in mode
// [R14] overhear done raises irq, result readable
// [R15] heard address muxed by select bits
// [R16] exit: rc standby then disable overhear
// [R17] type 00 raw, 01 filtered
// [R18] initiator irq when result ready
// [R19] readout only after completion interrupt
//
// Our own choice: strobed register access.
module ranging_host (
    // clock and reset
    input  wire logic        CLK,
    input  wire logic        RESET,
    // register port
    input  wire logic [3:0]  ADDR,
    input  wire logic [31:0] WDATA,
    input  wire logic        WR,
    input  wire logic        RD,
    output logic [31:0]      RDATA,
    // interrupt
    output logic             IRQ,
    // link
    ranging_link_if.host     link
);
    typedef enum logic [4:0] {
        S_IDLE     = 5'b00000,
        S_INIT     = 5'b00001,
        S_START    = 5'b00011,
        S_WAIT     = 5'b00010,
        S_XTAL     = 5'b00110,
        S_MCLK_RD  = 5'b00111,
        S_MCLK_WR  = 5'b00101,
        S_TYPE_RD  = 5'b00100,
        S_TYPE_WR  = 5'b01100,
        S_RES_RD   = 5'b01101,
        S_SEL_RD   = 5'b01111,
        S_SEL_WR   = 5'b01110,
        S_ADR_RD   = 5'b01010,
        S_RC       = 5'b01011,
        S_ERROR    = 5'b01001,
        S_EXIT_RC  = 5'b01000,
        S_EXIT_OFF = 5'b11000,
        S_ROLE     = 5'b11001,
        S_MODE_ON  = 5'b11011
    } seq_e;

    localparam int HIRQ_W = ranging_pkg::HIRQ_WIDTH;

    seq_e        state_q;
    logic        overhear_q;
    logic [1:0]  type_q;
    logic [7:0]  max_err_q;
    logic [7:0]  err_cnt_q;
    logic [1:0]  idx_q;
    logic        pair_q;
    logic [23:0] result_q;
    logic [31:0] address_q;
    logic [HIRQ_W-1:0] irq_stat_q;
    logic [HIRQ_W-1:0] irq_en_q;
    logic [HIRQ_W-1:0] irq_set;
    logic        go;
    logic        issued_q;
    logic [7:0]  op;
    logic [11:0] addr;
    logic [7:0]  data;
    logic        done;
    logic [7:0]  rdata;
    logic [7:0]  hold_q;
    logic        busy;
    logic        stop_req;

    ranging_link_cmd u_cmd (
        .clk   (CLK),
        .reset (RESET),
        .go    (go),
        .op    (op),
        .addr  (addr),
        .data  (data),
        .done  (done),
        .rdata (rdata),
        .link  (link)
    );

    assign busy     = (state_q != S_IDLE);
    assign stop_req = WR && ADDR == ranging_pkg::HREG_CTRL && WDATA[ranging_pkg::CTRL_STOP];
    assign go       = busy && !issued_q && state_q != S_WAIT && state_q != S_ERROR;

    always_comb begin
        op   = ranging_pkg::OP_REG_WRITE;
        addr = 12'h000;
        data = 8'h00;
        unique case (state_q)
            S_INIT:    begin op = ranging_pkg::OP_ROLE_SELECT; data = ranging_pkg::ARG_ROLE_INIT; end
            S_START:   op = ranging_pkg::OP_TX_START;  // [R06]
            S_XTAL:    begin op = ranging_pkg::OP_STANDBY; data = ranging_pkg::ARG_XTAL_STBY; end  // [R01]
            S_MCLK_RD: begin op = ranging_pkg::OP_REG_READ; addr = ranging_pkg::REG_MEM_CLK; end
            S_MCLK_WR: begin
                addr = ranging_pkg::REG_MEM_CLK;
                data = hold_q | ranging_pkg::MEM_CLK_BIT;  // [R02]
            end
            S_TYPE_RD: begin op = ranging_pkg::OP_REG_READ; addr = ranging_pkg::REG_RESULT_TYPE; end
            S_TYPE_WR: begin
                addr = ranging_pkg::REG_RESULT_TYPE;
                data = (hold_q & ranging_pkg::TYPE_KEEP_MASK)
                     | (8'(type_q & ranging_pkg::TYPE_VALUE_MASK)
                        << ranging_pkg::TYPE_SHIFT);  // [R03]
            end
            S_RES_RD:  begin
                op   = ranging_pkg::OP_REG_READ;
                addr = ranging_pkg::REG_RESULT_MSB + 12'(idx_q);  // [R04] [R07]
            end
            S_SEL_RD:  begin op = ranging_pkg::OP_REG_READ; addr = ranging_pkg::REG_HEARD_SEL; end
            S_SEL_WR:  begin
                addr = ranging_pkg::REG_HEARD_SEL;
                data = (hold_q & ranging_pkg::SEL_KEEP_MASK)
                     | {6'h00, pair_q ? ranging_pkg::SEL_HIGH_PAIR : ranging_pkg::SEL_LOW_PAIR};  // [R15]
            end
            S_ADR_RD:  begin
                op   = ranging_pkg::OP_REG_READ;
                addr = idx_q[0] ? ranging_pkg::REG_HEARD_HI : ranging_pkg::REG_HEARD_LO;
            end
            S_RC, S_EXIT_RC: begin op = ranging_pkg::OP_STANDBY; data = ranging_pkg::ARG_RC_STANDBY; end  // [R05] [R16]
            S_EXIT_OFF: begin op = ranging_pkg::OP_OVERHEAR_EN; data = ranging_pkg::ARG_MODE_OFF; end  // [R16]
            S_ROLE:    begin op = ranging_pkg::OP_ROLE_SELECT; data = ranging_pkg::ARG_ROLE_RESP; end  // [R11]
            S_MODE_ON: begin op = ranging_pkg::OP_OVERHEAR_EN; data = ranging_pkg::ARG_MODE_ON; end  // [R12]
            default:   op = ranging_pkg::OP_REG_WRITE;
        endcase
        if (state_q == S_START && overhear_q) op = ranging_pkg::OP_RX_START;  // [R12]
    end

    always_ff @(posedge CLK) begin
        if (RESET) issued_q <= 1'b0;
        else if (done) issued_q <= 1'b0;
        else if (go) issued_q <= 1'b1;
    end

    always_ff @(posedge CLK) begin
        if (RESET) begin
            state_q   <= S_IDLE;
            idx_q     <= 2'h0;
            pair_q    <= 1'b0;
            hold_q    <= 8'h00;
            err_cnt_q <= 8'h00;
            result_q  <= 24'h000000;
            address_q <= 32'h00000000;
        end else begin
            if (done) hold_q <= rdata;
            unique case (state_q)
                S_IDLE: if (WR && ADDR == ranging_pkg::HREG_CTRL) begin
                    err_cnt_q <= 8'h00;
                    if (WDATA[ranging_pkg::CTRL_OVERHEAR]) state_q <= S_ROLE;
                    else if (WDATA[ranging_pkg::CTRL_INIT]) state_q <= S_INIT;  // [R06]
                    else if (WDATA[ranging_pkg::CTRL_START]) state_q <= S_START;
                end
                S_ROLE:    if (done) state_q <= S_MODE_ON;
                S_MODE_ON: if (done) state_q <= S_START;
                S_INIT:    if (done) state_q <= S_START;
                S_START:   if (done) state_q <= S_WAIT;
                S_WAIT: begin
                    if (overhear_q && stop_req) state_q <= S_EXIT_RC;
                    else if (link.irq[15] && overhear_q) state_q <= S_XTAL;  // [R19] [R13]
                    else if (!overhear_q && (link.irq & ranging_pkg::IRQ_RESULT_BIT) != 16'h0000)
                        state_q <= S_XTAL;  // [R19]
                    else if ((link.irq & (ranging_pkg::IRQ_TIMEOUT_BIT
                                         | ranging_pkg::IRQ_DISCARD_BIT)) != 16'h0000)
                        state_q <= S_ERROR;  // [R08]
                end
                S_ERROR: begin
                    err_cnt_q <= err_cnt_q + 8'h01;
                    state_q   <= (err_cnt_q + 8'h01 >= max_err_q) ? S_IDLE : S_START;  // [R08]
                end
                S_XTAL:    if (done) state_q <= S_MCLK_RD;
                S_MCLK_RD: if (done) state_q <= S_MCLK_WR;
                S_MCLK_WR: if (done) state_q <= S_TYPE_RD;
                S_TYPE_RD: if (done) state_q <= S_TYPE_WR;
                S_TYPE_WR: if (done) begin
                    state_q <= S_RES_RD;
                    idx_q   <= 2'h0;
                end
                S_RES_RD: if (done) begin
                    result_q <= {result_q[15:0], rdata};
                    idx_q    <= idx_q + 2'h1;
                    if (idx_q == 2'h2) state_q <= S_RC;
                end
                S_RC: if (done) begin
                    state_q <= overhear_q ? S_SEL_RD : S_IDLE;
                    pair_q  <= 1'b0;
                end
                S_SEL_RD: if (done) state_q <= S_SEL_WR;
                S_SEL_WR: if (done) begin
                    state_q <= S_ADR_RD;
                    idx_q   <= 2'h0;
                end
                S_ADR_RD: if (done) begin
                    address_q <= {rdata, address_q[31:8]};
                    idx_q     <= idx_q + 2'h1;
                    if (idx_q[0]) begin
                        pair_q  <= 1'b1;
                        state_q <= pair_q ? S_START : S_SEL_RD;
                    end
                end
                S_EXIT_RC:  if (done) state_q <= S_EXIT_OFF;
                S_EXIT_OFF: if (done) state_q <= S_IDLE;
                default:    state_q <= S_IDLE;
            endcase
        end
    end

    always_ff @(posedge CLK) begin
        if (RESET) begin
            overhear_q <= 1'b0;
            type_q     <= ranging_pkg::TYPE_RAW;
            max_err_q  <= ranging_pkg::MAX_ERR_RESET;
        end else if (WR && ADDR == ranging_pkg::HREG_CTRL && !busy) begin
            overhear_q <= WDATA[ranging_pkg::CTRL_OVERHEAR];
            type_q     <= WDATA[ranging_pkg::CTRL_TYPE_LO +: 2];
        end else if (WR && ADDR == ranging_pkg::HREG_MAX_ERR) begin
            max_err_q  <= WDATA[7:0];
        end
    end

    // set wins over a simultaneous clear
    assign irq_set[ranging_pkg::HIRQ_RESULT] = state_q == S_RC && done;
    assign irq_set[ranging_pkg::HIRQ_ERROR]  = state_q == S_ERROR;
    assign irq_set[ranging_pkg::HIRQ_FAILED] = state_q == S_ERROR && err_cnt_q + 8'h01 >= max_err_q;

    always_ff @(posedge CLK) begin
        if (RESET) begin
            irq_stat_q <= '0;
            irq_en_q   <= '0;
            IRQ        <= 1'b0;
        end else begin
            irq_stat_q <= (irq_stat_q & ~((WR && ADDR == ranging_pkg::HREG_IRQ_CLR)
                                          ? WDATA[HIRQ_W-1:0] : '0)) | irq_set;
            if (WR && ADDR == ranging_pkg::HREG_IRQ_EN) irq_en_q <= WDATA[HIRQ_W-1:0];
            IRQ <= |(irq_stat_q & irq_en_q);
        end
    end

    always_ff @(posedge CLK) begin
        if (RESET) begin
            RDATA <= 32'h00000000;
        end else begin
            RDATA <= 32'h00000000;
            if (RD) begin
                unique case (ADDR)
                    ranging_pkg::HREG_CTRL:     RDATA <= {26'h0, type_q, 1'b0, overhear_q, 2'h0};
                    ranging_pkg::HREG_STATUS:   RDATA <= {19'h0, err_cnt_q, state_q};
                    ranging_pkg::HREG_RESULT:   RDATA <= {8'h00, result_q};
                    ranging_pkg::HREG_ADDRESS:  RDATA <= address_q;
                    ranging_pkg::HREG_IRQ_STAT: RDATA <= {29'h0, irq_stat_q};
                    ranging_pkg::HREG_IRQ_EN:   RDATA <= {29'h0, irq_en_q};
                    ranging_pkg::HREG_MAX_ERR:  RDATA <= {24'h0, max_err_q};
                    default:                    RDATA <= 32'h00000000;
                endcase
            end
        end
    end
endmodule

// File: verilog/ranging_pkg.sv
// shared constants for the ranging command link and both of its ends
package ranging_pkg;
    // command opcodes on the link
    localparam logic [7:0] OP_REG_WRITE    = 8'h18;
    localparam logic [7:0] OP_REG_READ     = 8'h19;
    localparam logic [7:0] OP_STANDBY      = 8'h80;
    localparam logic [7:0] OP_ROLE_SELECT  = 8'hA3;
    localparam logic [7:0] OP_OVERHEAR_EN  = 8'h9A;
    localparam logic [7:0] OP_RX_START     = 8'h82;
    localparam logic [7:0] OP_TX_START     = 8'h83;
    // command arguments
    localparam logic [7:0] ARG_RC_STANDBY  = 8'h00;
    localparam logic [7:0] ARG_XTAL_STBY   = 8'h01;
    localparam logic [7:0] ARG_ROLE_RESP   = 8'h00;
    localparam logic [7:0] ARG_ROLE_INIT   = 8'h01;
    localparam logic [7:0] ARG_MODE_OFF    = 8'h00;
    localparam logic [7:0] ARG_MODE_ON     = 8'h01;
    // device register map
    localparam logic [11:0] REG_RESULT_TYPE = 12'h924;
    localparam logic [11:0] REG_HEARD_SEL   = 12'h927;
    localparam logic [11:0] REG_HEARD_HI    = 12'h95F;
    localparam logic [11:0] REG_HEARD_LO    = 12'h960;
    localparam logic [11:0] REG_RESULT_MSB  = 12'h961;
    localparam logic [11:0] REG_RESULT_MID  = 12'h962;
    localparam logic [11:0] REG_RESULT_LSB  = 12'h963;
    localparam logic [11:0] REG_MEM_CLK     = 12'h97F;
    // fields
    localparam logic [7:0] MEM_CLK_BIT      = 8'h02;
    localparam logic [7:0] TYPE_KEEP_MASK   = 8'hCF;
    localparam logic [1:0] TYPE_VALUE_MASK  = 2'h3;
    localparam int         TYPE_SHIFT       = 4;
    localparam logic [7:0] SEL_KEEP_MASK    = 8'hFC;
    localparam logic [1:0] SEL_LOW_PAIR     = 2'h0;
    localparam logic [1:0] SEL_HIGH_PAIR    = 2'h1;
    localparam logic [1:0] TYPE_RAW         = 2'h0;
    localparam logic [1:0] TYPE_FILTERED    = 2'h1;
    // interrupt line bits (device side)
    localparam logic [15:0] IRQ_DONE_BIT    = 16'h8000;
    localparam logic [15:0] IRQ_RESULT_BIT  = 16'h0200;
    localparam logic [15:0] IRQ_TIMEOUT_BIT = 16'h0400;
    localparam logic [15:0] IRQ_DISCARD_BIT = 16'h0100;
    // host register port offsets
    localparam logic [3:0] HREG_CTRL        = 4'h0;
    localparam logic [3:0] HREG_STATUS      = 4'h1;
    localparam logic [3:0] HREG_RESULT      = 4'h2;
    localparam logic [3:0] HREG_ADDRESS     = 4'h3;
    localparam logic [3:0] HREG_IRQ_STAT    = 4'h4;
    localparam logic [3:0] HREG_IRQ_EN      = 4'h5;
    localparam logic [3:0] HREG_IRQ_CLR     = 4'h6;
    localparam logic [3:0] HREG_MAX_ERR     = 4'h7;
    // host control bits
    localparam int CTRL_START    = 0;
    localparam int CTRL_INIT     = 1;
    localparam int CTRL_OVERHEAR = 2;
    localparam int CTRL_STOP     = 3;
    localparam int CTRL_TYPE_LO  = 4;
    // host interrupt bits
    localparam int HIRQ_RESULT  = 0;
    localparam int HIRQ_ERROR   = 1;
    localparam int HIRQ_FAILED  = 2;
    localparam int HIRQ_WIDTH   = 3;
    localparam logic [7:0] MAX_ERR_RESET = 8'h03;
endpackage

// File: verilog/ranging_link_if.sv
// command link between host sequencer and ranging device
interface ranging_link_if;
    logic        cmd_valid;
    logic [7:0]  cmd_op;
    logic [11:0] cmd_addr;
    logic [7:0]  cmd_data;
    logic        rsp_valid;
    logic [7:0]  rsp_data;
    logic [15:0] irq;
    modport host (output cmd_valid, cmd_op, cmd_addr, cmd_data, input rsp_valid, rsp_data, irq);
    modport dev  (input cmd_valid, cmd_op, cmd_addr, cmd_data, output rsp_valid, rsp_data, irq);
endinterface

// File: verilog/ranging_link_cmd.sv
// issues one link command and waits for its answer when it reads
module ranging_link_cmd (
    // clock and reset
    input  wire logic        clk,
    input  wire logic        reset,
    // request
    input  wire logic        go,
    input  wire logic [7:0]  op,
    input  wire logic [11:0] addr,
    input  wire logic [7:0]  data,
    output logic             done,
    output logic [7:0]       rdata,
    // link
    ranging_link_if.host     link
);
    logic waiting_q;

    always_ff @(posedge clk) begin
        if (reset) begin
            link.cmd_valid <= 1'b0;
            link.cmd_op    <= 8'h00;
            link.cmd_addr  <= 12'h000;
            link.cmd_data  <= 8'h00;
        end else begin
            link.cmd_valid <= go;
            if (go) begin
                link.cmd_op   <= op;
                link.cmd_addr <= addr;
                link.cmd_data <= data;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            waiting_q <= 1'b0;
            done      <= 1'b0;
            rdata     <= 8'h00;
        end else begin
            done <= 1'b0;
            if (go && op == ranging_pkg::OP_REG_READ) begin
                waiting_q <= 1'b1;
            end else if (go) begin
                done <= 1'b1;
            end else if (waiting_q && link.rsp_valid) begin
                waiting_q <= 1'b0;
                rdata     <= link.rsp_data;
                done      <= 1'b1;
            end
        end
    end
endmodule

// File: verilog/ranging_dev.sv
// device end: register file, result and overheard address, interrupt line
module ranging_dev (
    // clock and reset
    input  wire logic        CLK,
    input  wire logic        RESET,
    // measurement engine
    input  wire logic        RESULT_STROBE,
    input  wire logic [23:0] RESULT_RAW,
    input  wire logic [23:0] RESULT_FILTERED,
    input  wire logic [31:0] HEARD_ADDRESS,
    input  wire logic        TIMEOUT_STROBE,
    input  wire logic        DISCARD_STROBE,
    input  wire logic        PREAMBLE_STROBE,
    // state
    output logic             OVERHEAR_MODE,
    output logic             ROLE_INITIATOR,
    output logic             XTAL_STANDBY,
    output logic             RX_ACTIVE,
    output logic             TX_ACTIVE,
    // link
    ranging_link_if.dev      link
);
    logic [7:0]  type_reg_q;
    logic [7:0]  sel_reg_q;
    logic [7:0]  memclk_q;
    logic [23:0] raw_q;
    logic [23:0] filt_q;
    logic [31:0] heard_q;
    logic [23:0] result_view;
    logic [7:0]  rd_d;

    always_ff @(posedge CLK) begin
        if (RESET) begin
            OVERHEAR_MODE  <= 1'b0;
            ROLE_INITIATOR <= 1'b0;
            XTAL_STANDBY   <= 1'b0;
            RX_ACTIVE      <= 1'b0;
            TX_ACTIVE      <= 1'b0;
        end else if (link.cmd_valid) begin
            unique case (link.cmd_op)
                ranging_pkg::OP_STANDBY: begin
                    XTAL_STANDBY <= (link.cmd_data == ranging_pkg::ARG_XTAL_STBY);
                    RX_ACTIVE    <= 1'b0;
                    TX_ACTIVE    <= 1'b0;
                end
                ranging_pkg::OP_ROLE_SELECT: begin
                    ROLE_INITIATOR <= (link.cmd_data == ranging_pkg::ARG_ROLE_INIT);
                end
                ranging_pkg::OP_OVERHEAR_EN: begin
                    OVERHEAR_MODE <= (link.cmd_data == ranging_pkg::ARG_MODE_ON);
                end
                ranging_pkg::OP_RX_START: begin
                    RX_ACTIVE <= 1'b1;
                end
                ranging_pkg::OP_TX_START: begin
                    TX_ACTIVE <= 1'b1;
                end
                default: begin
                end
            endcase
        end
    end

    // writable registers
    always_ff @(posedge CLK) begin
        if (RESET) begin
            type_reg_q <= 8'h00;
            sel_reg_q  <= 8'h00;
            memclk_q   <= 8'h00;
        end else if (link.cmd_valid && link.cmd_op == ranging_pkg::OP_REG_WRITE) begin
            if (link.cmd_addr == ranging_pkg::REG_RESULT_TYPE) type_reg_q <= link.cmd_data;
            if (link.cmd_addr == ranging_pkg::REG_HEARD_SEL)   sel_reg_q  <= link.cmd_data;
            if (link.cmd_addr == ranging_pkg::REG_MEM_CLK)     memclk_q   <= link.cmd_data;
        end
    end

    // results are captured by the engine; response leg needs no host help
    always_ff @(posedge CLK) begin
        if (RESET) begin
            raw_q   <= 24'h000000;
            filt_q  <= 24'h000000;
            heard_q <= 32'h00000000;
        end else if (RESULT_STROBE && (RX_ACTIVE || TX_ACTIVE)) begin  // [R09] [R10]
            raw_q  <= RESULT_RAW;
            filt_q <= RESULT_FILTERED;
            if (OVERHEAR_MODE) heard_q <= HEARD_ADDRESS;
        end
    end

    // filtered only when the type field says 01
    assign result_view = (type_reg_q[5:4] == ranging_pkg::TYPE_FILTERED) ? filt_q : raw_q;  // [R17]

    always_comb begin
        rd_d = 8'h00;
        unique case (link.cmd_addr)
            ranging_pkg::REG_RESULT_TYPE: rd_d = type_reg_q;
            ranging_pkg::REG_HEARD_SEL:   rd_d = sel_reg_q;
            ranging_pkg::REG_MEM_CLK:     rd_d = memclk_q;
            ranging_pkg::REG_RESULT_MSB:  rd_d = result_view[23:16];  // [R04]
            ranging_pkg::REG_RESULT_MID:  rd_d = result_view[15:8];  // [R04]
            ranging_pkg::REG_RESULT_LSB:  rd_d = result_view[7:0];  // [R04]
            ranging_pkg::REG_HEARD_LO:
                rd_d = (sel_reg_q[1:0] == ranging_pkg::SEL_HIGH_PAIR) ? heard_q[23:16]
                                                                      : heard_q[7:0];  // [R15]
            ranging_pkg::REG_HEARD_HI:
                rd_d = (sel_reg_q[1:0] == ranging_pkg::SEL_HIGH_PAIR) ? heard_q[31:24]
                                                                      : heard_q[15:8];  // [R15]
            default: rd_d = 8'h00;
        endcase
    end

    always_ff @(posedge CLK) begin
        if (RESET) begin
            link.rsp_valid <= 1'b0;
            link.rsp_data  <= 8'h00;
        end else begin
            link.rsp_valid <= link.cmd_valid && link.cmd_op == ranging_pkg::OP_REG_READ;
            link.rsp_data  <= rd_d;
        end
    end

    // one-cycle interrupt pulses; bit 15 meaning depends on mode
    always_ff @(posedge CLK) begin
        if (RESET) begin
            link.irq <= 16'h0000;
        end else begin
            link.irq <= 16'h0000;
            if (OVERHEAR_MODE && RESULT_STROBE && RX_ACTIVE)
                link.irq <= ranging_pkg::IRQ_DONE_BIT;  // [R13] [R14]
            else if (!OVERHEAR_MODE && PREAMBLE_STROBE)
                link.irq <= ranging_pkg::IRQ_DONE_BIT;  // [R13]
            else if (!OVERHEAR_MODE && ROLE_INITIATOR && RESULT_STROBE && TX_ACTIVE)
                link.irq <= ranging_pkg::IRQ_RESULT_BIT;  // [R18]
            else if (ROLE_INITIATOR && TIMEOUT_STROBE && TX_ACTIVE)
                link.irq <= ranging_pkg::IRQ_TIMEOUT_BIT;
            else if (!ROLE_INITIATOR && DISCARD_STROBE && RX_ACTIVE)
                link.irq <= ranging_pkg::IRQ_DISCARD_BIT;
        end
    end
endmodule

// File: verif/ranging_link_monitor.sv
// assertions on the ranging command link
module ranging_link_monitor (
    // clock, reset
    input wire logic        CLK,
    input wire logic        RESET,
    // link
    input wire logic        cmd_valid,
    input wire logic [7:0]  cmd_op,
    input wire logic [11:0] cmd_addr,
    input wire logic [7:0]  cmd_data,
    input wire logic        rsp_valid,
    input wire logic [7:0]  rsp_data,
    input wire logic [15:0] irq
);
    logic        xtal_q, seen_q, resp_q;
    logic [11:0] ra_q, la_q;
    logic [7:0]  ld_q;
    wire rdc = cmd_valid && cmd_op == ranging_pkg::OP_REG_READ;
    wire wrc = cmd_valid && cmd_op == ranging_pkg::OP_REG_WRITE;
    wire sby = cmd_valid && cmd_op == ranging_pkg::OP_STANDBY;
    wire ovh = cmd_valid && cmd_op == ranging_pkg::OP_OVERHEAR_EN;
    wire msb = rdc && cmd_addr == ranging_pkg::REG_RESULT_MSB;
    wire fin = (irq & (ranging_pkg::IRQ_DONE_BIT | ranging_pkg::IRQ_RESULT_BIT)) != 16'h0;
    always_ff @(posedge CLK) begin
        if (RESET) xtal_q <= 1'h0;
        else if (sby) xtal_q <= cmd_data == ranging_pkg::ARG_XTAL_STBY;
    end
    // rc standby closes a readout, so the next one needs a fresh completion
    always_ff @(posedge CLK) begin
        if (RESET || (sby && cmd_data == ranging_pkg::ARG_RC_STANDBY)) seen_q <= 1'h0;
        else if (fin) seen_q <= 1'h1;
    end
    always_ff @(posedge CLK) begin
        if (RESET) resp_q <= 1'h0;
        else if (cmd_valid && cmd_op == ranging_pkg::OP_ROLE_SELECT) resp_q <= cmd_data == 8'h00;
    end
    always_ff @(posedge CLK) begin
        if (rdc) ra_q <= cmd_addr;
        if (RESET) la_q <= 12'h000;
        else if (rsp_valid) la_q <= ra_q;
        if (rsp_valid) ld_q <= rsp_data;
    end
    default clocking @(posedge CLK); endclocking
    default disable iff (RESET);
    a_read_answer: assert property (rdc |=> rsp_valid && !cmd_valid) else $error("no answer");
    a_no_stray: assert property (rsp_valid |-> $past(rdc)) else $error("stray answer");
    a_xtal_first: assert property (msb |-> xtal_q) else $error("readout in rc");
    a_irq_first: assert property (msb |-> seen_q) else $error("readout early");
    a_memclk_rmw: assert property (wrc && cmd_addr == ranging_pkg::REG_MEM_CLK |->
        la_q == ranging_pkg::REG_MEM_CLK && cmd_data == (ld_q | 8'h02)) else $error("memclk");
    a_type_keep: assert property (wrc && cmd_addr == ranging_pkg::REG_RESULT_TYPE |->
        la_q == cmd_addr && ((cmd_data ^ ld_q) & 8'hCF) == 8'h00) else $error("type rmw");
    a_role_first: assert property (ovh && cmd_data == 8'h01 |-> resp_q) else $error("role");
    a_exit_order: assert property (ovh && cmd_data == 8'h00 |-> !xtal_q) else $error("exit");
endmodule

// File: verif/tb_ranging_result_and_overhear_ctrl.sv
// random two-end bench for the ranging sequencer and device
module tb_ranging_result_and_overhear_ctrl;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk, reset, wr, rd, stb, tmo, irq, rxa, txa;
    logic [3:0]  addr;
    logic [31:0] wdata, rdata, s, v, ha;
    logic [23:0] raw, filt;
    int          fails, tests_run, t, i;
    ranging_link_if link ();
    ranging_host u_ranging_host (.CLK(clk), .RESET(reset), .ADDR(addr), .WDATA(wdata),
        .WR(wr), .RD(rd), .RDATA(rdata), .IRQ(irq), .link(link));
    ranging_dev u_ranging_dev (.CLK(clk), .RESET(reset), .RESULT_STROBE(stb), .RESULT_RAW(raw),
        .RESULT_FILTERED(filt), .HEARD_ADDRESS(ha), .TIMEOUT_STROBE(tmo),
        .DISCARD_STROBE(1'h0), .PREAMBLE_STROBE(1'h0), .OVERHEAR_MODE(), .ROLE_INITIATOR(),
        .XTAL_STANDBY(), .RX_ACTIVE(rxa), .TX_ACTIVE(txa), .link(link));
    ranging_link_monitor u_ranging_link_monitor (.CLK(clk), .RESET(reset),
        .cmd_valid(link.cmd_valid), .cmd_op(link.cmd_op), .cmd_addr(link.cmd_addr),
        .cmd_data(link.cmd_data), .rsp_valid(link.rsp_valid), .rsp_data(link.rsp_data),
        .irq(link.irq));
    function automatic logic [31:0] nx(input logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction
    function automatic logic [31:0] want(input int k);
        return {8'h00, k == 1 ? filt : raw};
    endfunction
    task chk(input logic [31:0] g, input logic [31:0] e);
        tests_run++;
        if (g !== e) begin
            fails++;
            $display("BAD %0t got %h want %h", $time, g, e);
        end
    endtask
    task wrr(input logic [3:0] a, input logic [31:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'h1;
        @(posedge clk);
        wr <= 1'h0;
    endtask
    task rdd(input logic [3:0] a);
        @(posedge clk);
        addr <= a;
        rd <= 1'h1;
        @(posedge clk);
        rd <= 1'h0;
        #1 v = rdata;
    endtask
    task final_report;
        $display("checks %0d mismatches %0d", tests_run, fails);
        if (fails == 0 && tests_run > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    initial begin
        clk = 1'h0;
        forever #4 clk = ~clk;
    end
    // whole run is a few hundred cycles
    initial begin
        #200000;
        fails++;
        final_report;
    end
    initial begin
        {reset, wr, rd, stb, tmo, addr, wdata, raw, filt, ha} = {1'h1, 120'h0};
        s = 32'h7B28D80C;
        repeat (4) @(posedge clk);
        reset <= 1'h0;
        wrr(ranging_pkg::HREG_IRQ_EN, 32'h1);
        // runs: raw, filtered, timeout then retry, overhear
        for (t = 0; t < 4; t++) begin
            s = nx(s);
            raw <= t == 0 ? 24'hFFFFFF : s[23:0];
            filt <= s[31:8];
            ha <= nx(s);
            wrr(ranging_pkg::HREG_CTRL, t == 3 ? 32'h4 : 32'h2 | (32'(t) << 4));
            for (i = 0; i < 300 && !(rxa || txa); i++) @(posedge clk);
            // one timeout first; the retry must be back in wait before the result
            if (t == 2) begin
                tmo <= 1'h1;
                @(posedge clk);
                tmo <= 1'h0;
                repeat (6) @(posedge clk);
            end
            stb <= 1'h1;
            @(posedge clk);
            stb <= 1'h0;
            for (i = 0; i < 300 && irq !== 1'h1; i++) @(posedge clk);
            rdd(ranging_pkg::HREG_IRQ_STAT);
            chk(v, t == 2 ? 32'h3 : 32'h1);
            rdd(ranging_pkg::HREG_RESULT);
            chk(v, want(t));
            // heard address is fetched after rc standby, so wait for reception again
            if (t == 3) for (i = 0; i < 300 && rxa !== 1'h1; i++) @(posedge clk);
            if (t == 3) chk(32'(rxa), 32'h1);
            if (t == 3) rdd(ranging_pkg::HREG_ADDRESS);
            if (t == 3) chk(v, ha);
            wrr(ranging_pkg::HREG_IRQ_CLR, 32'h3);
            $display("test %0d done", t);
        end
        wrr(ranging_pkg::HREG_CTRL, 32'h8);
        repeat (30) @(posedge clk);
        final_report;
    end
endmodule
